// ---- rtl/ext_irq_pkg.sv ----
// Package of constants and types for the external interrupt conditioning block
`default_nettype none
package ext_irq_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int LINE_COUNT = 6;
   localparam int CNT_W = 8;

   // ----------------------------------------
   // Register map (index times four gives the byte address)
   // ----------------------------------------
   localparam logic [7:0] CONTROL_INDEX = 8'h37;
   localparam logic [7:0] STATUS_INDEX = 8'h38;
   localparam logic [9:0] CONTROL_ADDR = {CONTROL_INDEX, 2'b00};
   localparam logic [9:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hfe;

   // Field positions inside the control byte
   localparam int FILTER_SELECT_BIT = 7;
   localparam int PIN_SELECT_BIT = 6;
   localparam int TRIGGER4_LSB = 4;
   localparam int EDGE3_BIT = 3;
   localparam int EDGE2_BIT = 2;
   localparam int EDGE1_BIT = 1;

   // Field positions inside the status word
   localparam int STATUS_LATCH_LSB = 0;
   localparam int STATUS_LEVEL_LSB = 8;

   // ----------------------------------------
   // Timing: reject times in periods of the high-frequency clock
   // ----------------------------------------
   localparam longint CLOCK_HZ = 200_000_000;
   localparam longint HIGH_FREQ_HZ = 200_000_000;
   localparam longint REJECT_FC_LINE05 = 2;
   localparam longint REJECT_FC_LINE1_LONG = 63;
   localparam longint REJECT_FC_LINE1_SHORT = 15;
   localparam longint REJECT_FC_LINE234 = 7;
   // Reject time in periods of the low-frequency clock
   localparam longint REJECT_FS_ALL = 1;
   // Ticks needed in slow mode: under 1/fs holds at most one tick, 3.5/fs at least three
   localparam logic [CNT_W-1:0] SLOW_TICKS = CNT_W'(REJECT_FS_ALL + 1);

   // Least times round up to whole cycles
   localparam logic [CNT_W-1:0] CYC_LINE05 =
      CNT_W'((REJECT_FC_LINE05 * CLOCK_HZ + HIGH_FREQ_HZ - 1) / HIGH_FREQ_HZ);
   localparam logic [CNT_W-1:0] CYC_LINE1_LONG =
      CNT_W'((REJECT_FC_LINE1_LONG * CLOCK_HZ + HIGH_FREQ_HZ - 1) / HIGH_FREQ_HZ);
   localparam logic [CNT_W-1:0] CYC_LINE1_SHORT =
      CNT_W'((REJECT_FC_LINE1_SHORT * CLOCK_HZ + HIGH_FREQ_HZ - 1) / HIGH_FREQ_HZ);
   localparam logic [CNT_W-1:0] CYC_LINE234 =
      CNT_W'((REJECT_FC_LINE234 * CLOCK_HZ + HIGH_FREQ_HZ - 1) / HIGH_FREQ_HZ);

   // Cycles after reset release before edges are believed
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TRIG_RISE,
      TRIG_FALL,
      TRIG_BOTH,
      TRIG_LEVEL
   } trigger_t;

   // Control byte as stored
   typedef struct packed {
      logic line1_filter_select;
      logic line0_pin_select;
      logic [1:0] line4_trigger_select;
      logic line3_edge_select;
      logic line2_edge_select;
      logic line1_edge_select;
      logic unused;
   } control_t;

   // Enable conditions from the interrupt controller
   typedef struct packed {
      logic master_irq_enable;
      logic [LINE_COUNT-1:0] individual_enable;
   } enable_t;
endpackage
`default_nettype wire

// ---- rtl/noise_filter.sv ----
// Digital noise filter with synchroniser, sampling counter and edge outputs
`default_nettype none
module noise_filter
   import ext_irq_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic pin,
   input wire logic sample_tick,
   input wire logic [ext_irq_pkg::CNT_W-1:0] threshold,
   output logic filtered,
   output logic rise,
   output logic fall,
   output logic settled
);
   import ext_irq_pkg::*;

   logic sync_a; // First stage, read only by sync_b
   logic sync_b; // Pin level safe to use
   logic [CNT_W-1:0] run_count; // Consecutive samples that disagree
   logic [1:0] settle_count; // Cycles since reset release
   logic [CNT_W-1:0] next_count;

   // ----------------------------------------
   // Synchroniser
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else if (ce) begin
         sync_a <= pin;
         sync_b <= sync_a;
      end
   end

   // Count plus one, cut to width on purpose
   assign next_count = CNT_W'(run_count + 1'b1);

   // ----------------------------------------
   // Sampling counter: a level must persist for threshold samples
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         filtered <= 1'b0;
         run_count <= '0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else if (ce) begin
         rise <= 1'b0;
         fall <= 1'b0;
         if (!settled) begin
            // Take the pin level as it is, so a line held high is no edge
            filtered <= sync_b;
            run_count <= '0;
         end else if (sync_b == filtered) begin
            // Agreement wipes any partial pulse
            run_count <= '0;
         end else if (sample_tick) begin
            if (next_count >= threshold) begin
               // Pulse long enough: accept and flag the edge
               filtered <= sync_b;
               run_count <= '0;
               rise <= sync_b;
               fall <= !sync_b;
            end else begin
               run_count <= next_count;
            end
         end
         // A threshold lowered mid-pulse takes hold on the next sample
         if (!settled || sample_tick) begin
            if (run_count > threshold) begin
               run_count <= '0;
            end
         end
      end
   end

   // ----------------------------------------
   // Settle counter after reset
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         settle_count <= '0;
         settled <= 1'b0;
      end else if (ce) begin
         if (settle_count != SETTLE_CYCLES) begin
            settle_count <= settle_count + 2'h1;
         end else begin
            settled <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/external_irq_filter_edge.sv ----
// Top of the external interrupt conditioning block with its register slave
// --------------------
// Overview
// --------------------
// Each pin crosses into our domain through two
// flip-flops inside its filter. A counter then
// demands that a new level persists for a set
// number of samples before the clean level moves.
// Detection acts on the clean level only.
// Fast mode samples every cycle; slow mode samples
// on low-frequency clock rises, shared by all lines.
//
// --------------------
// Latency
// --------------------
// Pin edge to latch: two synchroniser cycles, the
// sample count, one latch cycle; the edge flag
// comes with the accept.
// Accept follows the latch one cycle later.
// In slow mode the count is in slow ticks, so the
// delay grows with that clock's period.
// A pin that agrees again restarts the count.
//
// --------------------
// Line 1 reject time
// --------------------
// The limit follows the control bit at once. A
// count already past a lowered limit is accepted
// at its next sample, and flags its edge then.
//
// --------------------
// Level trigger on line 4
// --------------------
// Arms only after a clean rise since reset, so a
// line held high through reset raises nothing.
// Once armed it stays armed until reset, and the
// latch re-sets every cycle the line is high.
//
// --------------------
// Shared pin
// --------------------
// With pin select clear the line 0 latch never
// sets. The filter still runs, so the level shows
// in the status word for port use.
//
// --------------------
// Register bus
// --------------------
// Every access waits one cycle: waitrequest drops
// the cycle after a request, rises as it is taken.
// Read data loads while waiting and holds until
// the next read.
//
// --------------------
// Limitations
// --------------------
// Nothing stops glitches while software rewrites
// control or switches clocks; it masks first.
// Enables gate accepts only; latches set anyway.
// Clock enable low freezes all, the bus included.
// Divider clock select is not modelled.
// Control bit 0 is never stored and reads zero.
// Pin edges in the first cycles after reset are lost.
`default_nettype none
module external_irq_filter_edge
   import ext_irq_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Pins and clocks from outside
   input wire logic [ext_irq_pkg::LINE_COUNT-1:0] ext_irq_line,
   input wire logic low_freq_clock,
   // Operating mode and enables from the rest of the chip
   input wire logic slow_mode,
   input wire ext_irq_pkg::enable_t enables,
   input wire logic [ext_irq_pkg::LINE_COUNT-1:0] latch_clear,
   // Results
   output logic [ext_irq_pkg::LINE_COUNT-1:0] request_latch,
   output logic [ext_irq_pkg::LINE_COUNT-1:0] irq_accept,
   output logic shared_pin_is_irq
);
   import ext_irq_pkg::*;

   control_t control; // Software-visible control byte
   logic fs_sync_a; // First stage, read only by fs_sync_b
   logic fs_sync_b; // Low-frequency clock in our domain
   logic fs_prev; // Previous level for edge detection
   logic fs_tick; // One cycle per low-frequency rising edge
   logic sample_tick; // Sampling strobe for all filters
   logic [LINE_COUNT-1:0] filtered; // Clean line levels
   logic [LINE_COUNT-1:0] rise; // Accepted rising edges
   logic [LINE_COUNT-1:0] fall; // Accepted falling edges
   logic [LINE_COUNT-1:0] settled; // Filters past their start-up phase
   logic [LINE_COUNT-1:0] set_pulse; // Latch set requests this cycle
   logic [CNT_W-1:0] threshold [LINE_COUNT]; // Per-line sample count
   trigger_t trigger [LINE_COUNT]; // Per-line detection mode
   logic level_armed; // Line 4 saw a rising edge since reset
   logic bus_take; // Request taken at this edge
   logic [31:0] next_readdata;

   // ----------------------------------------
   // Low-frequency clock crossing and tick
   // ----------------------------------------
   // Sampled as a level; its rising edges become single-cycle ticks
   always_ff @(posedge clock) begin
      if (srst) begin
         fs_sync_a <= 1'b0;
         fs_sync_b <= 1'b0;
         fs_prev <= 1'b0;
      end else if (ce) begin
         fs_sync_a <= low_freq_clock;
         fs_sync_b <= fs_sync_a;
         fs_prev <= fs_sync_b;
      end
   end

   assign fs_tick = fs_sync_b && !fs_prev;
   // High-speed filters sample every cycle, slow ones on the tick
   assign sample_tick = slow_mode ? fs_tick : 1'b1;

   // ----------------------------------------
   // Per-line thresholds and trigger modes
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < LINE_COUNT; i++) begin
         threshold[i] = CYC_LINE234;
         trigger[i] = TRIG_FALL;
      end
      threshold[0] = CYC_LINE05;
      threshold[5] = CYC_LINE05;
      // Short setting accepts from 15, long from 63 cycles of pulse
      threshold[1] = control.line1_filter_select ? CYC_LINE1_SHORT : CYC_LINE1_LONG;
      trigger[1] = control.line1_edge_select ? TRIG_FALL : TRIG_RISE;
      trigger[2] = control.line2_edge_select ? TRIG_FALL : TRIG_RISE;
      trigger[3] = control.line3_edge_select ? TRIG_FALL : TRIG_RISE;
      trigger[4] = trigger_t'(control.line4_trigger_select);
      if (slow_mode) begin
         // One tick rejects, three ticks accept, whatever the line
         for (int i = 0; i < LINE_COUNT; i++) begin
            threshold[i] = SLOW_TICKS;
         end
      end
   end

   // ----------------------------------------
   // Filters and trigger detection, one per line
   // ----------------------------------------
   generate
      for (genvar g = 0; g < LINE_COUNT; g++) begin : line
         noise_filter filter (
            .clock(clock),
            .srst(srst),
            .ce(ce),
            .pin(ext_irq_line[g]),
            .sample_tick(sample_tick),
            .threshold(threshold[g]),
            .filtered(filtered[g]),
            .rise(rise[g]),
            .fall(fall[g]),
            .settled(settled[g])
         );

         // Detection on the filtered level, one set pulse per edge, one per high cycle in level mode
         always_comb begin
            unique case (trigger[g])
               TRIG_RISE: set_pulse[g] = rise[g];
               TRIG_FALL: set_pulse[g] = fall[g];
               TRIG_BOTH: set_pulse[g] = rise[g] || fall[g];
               TRIG_LEVEL: set_pulse[g] = filtered[g] && level_armed;
            endcase
         end

         // Latch: hardware set beats a clear in the same cycle
         always_ff @(posedge clock) begin
            if (srst) begin
               request_latch[g] <= 1'b0;
            end else if (ce) begin
               if (set_pulse[g] && (g != 0 || control.line0_pin_select)) begin
                  request_latch[g] <= 1'b1;
               end else if (latch_clear[g]) begin
                  request_latch[g] <= 1'b0;
               end
            end
         end

         // Acceptance gating follows the latch by one cycle
         always_ff @(posedge clock) begin
            if (srst) begin
               irq_accept[g] <= 1'b0;
            end else if (ce) begin
               irq_accept[g] <= request_latch[g] && enables.master_irq_enable
                  && enables.individual_enable[g]
                  && (g != 0 || control.line0_pin_select);
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Line 4 level arming
   // ----------------------------------------
   // A line already high at reset release shows no rise, so it stays quiet
   always_ff @(posedge clock) begin
      if (srst) begin
         level_armed <= 1'b0;
      end else if (ce) begin
         if (rise[4]) begin
            level_armed <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Avalon-MM slave: one wait cycle for every access
   // ----------------------------------------
   assign bus_take = (read || write) && !waitrequest;

   always_ff @(posedge clock) begin
      if (srst) begin
         waitrequest <= 1'b1;
      end else if (ce) begin
         // Drop for one cycle after a request appears, then rise again
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      next_readdata = '0;
      if (address == CONTROL_ADDR) begin
         next_readdata[7:0] = control & CONTROL_WRITE_MASK;
      end else if (address == STATUS_ADDR) begin
         next_readdata[STATUS_LATCH_LSB +: LINE_COUNT] = request_latch;
         next_readdata[STATUS_LEVEL_LSB +: LINE_COUNT] = filtered;
      end
   end

   // Read data loads while waitrequest is high and stands at the taking edge
   always_ff @(posedge clock) begin
      if (srst) begin
         readdata <= '0;
      end else if (ce) begin
         if (read && waitrequest) begin
            readdata <= next_readdata;
         end
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Writes take effect at once; software is expected to mask lines first
   always_ff @(posedge clock) begin
      if (srst) begin
         control <= control_t'(CONTROL_RESET);
      end else if (ce) begin
         if (bus_take && write && byteenable[0] && address == CONTROL_ADDR) begin
            control <= control_t'(writedata[7:0] & CONTROL_WRITE_MASK);
         end
      end
   end

   // ----------------------------------------
   // Shared pin function to the port logic
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         shared_pin_is_irq <= 1'b0;
      end else if (ce) begin
         shared_pin_is_irq <= control.line0_pin_select;
      end
   end
endmodule
`default_nettype wire

// ---- dv/ext_irq_checker_properties.sv ----
// Port-level assertions for the external interrupt conditioning block
`default_nettype none
module ext_irq_checker
   import ext_irq_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire ext_irq_pkg::enable_t enables,
   input wire logic [ext_irq_pkg::LINE_COUNT-1:0] latch_clear,
   input wire logic [ext_irq_pkg::LINE_COUNT-1:0] request_latch,
   input wire logic [ext_irq_pkg::LINE_COUNT-1:0] irq_accept,
   input wire logic shared_pin_is_irq
);
   // ------
   // Sequences
   // ------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // A bus request still waiting for its answer
   sequence bus_req_s;
      (read || write) && waitrequest;
   endsequence
   // Pin held as a port long enough to drain any edge in flight
   sequence port_mode_s;
      !shared_pin_is_irq [*4];
   endsequence
   // ------
   // Assertions
   // ------
   wait_bound_a: assert property (bus_req_s |-> ##[0:2] !waitrequest)
      else $error("bus request left without answer");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   reset_state_a: assert property ($fell(srst) |-> waitrequest && !shared_pin_is_irq
      && request_latch == '0 && irq_accept == '0)
      else $error("outputs not at reset values");
   accept_gate_a: assert property (!$past(srst) |-> irq_accept[5:1] ==
      $past(request_latch[5:1] & enables.individual_enable[5:1]
      & {5{enables.master_irq_enable}}))
      else $error("accept of lines 1 to 5 disagrees with latch and enables");
   line0_gate_a: assert property (irq_accept[0] |-> $past(request_latch[0])
      && $past(enables.individual_enable[0]) && (shared_pin_is_irq || $past(shared_pin_is_irq)))
      else $error("line 0 accepted without its conditions");
   master_off_a: assert property (!$past(enables.master_irq_enable) && !$past(srst)
      |-> irq_accept == '0)
      else $error("accept while master enable clear");
   latch_hold_a: assert property (!$past(srst) |->
      ($past(request_latch) & ~request_latch & ~$past(latch_clear)) == '0)
      else $error("latch dropped without clear");
   port_block_a: assert property (port_mode_s |-> !$rose(request_latch[0]))
      else $error("line 0 latched while pin is a port");
endmodule
bind external_irq_filter_edge ext_irq_checker checker_inst (.clock(clock), .srst(srst),
   .read(read), .write(write), .waitrequest(waitrequest), .enables(enables),
   .latch_clear(latch_clear), .request_latch(request_latch), .irq_accept(irq_accept),
   .shared_pin_is_irq(shared_pin_is_irq));
`default_nettype wire

// ---- dv/pin_source.sv ----
// Model of the outside sources driving the interrupt pins and the slow clock
`default_nettype none
module pin_source
   import ext_irq_pkg::*;
(
   input wire logic clock,
   input wire logic fs_on,
   output logic [ext_irq_pkg::LINE_COUNT-1:0] ext_irq_line,
   output logic low_freq_clock
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] fs_count; // Slow clock divider, period of 16 fast cycles
   // ------
   // Start-up levels
   // ------
   initial begin
      ext_irq_line = 6'h21; // Falling-edge lines idle high
      low_freq_clock = 1'b0;
      fs_count = 4'h0;
   end
   // Slow clock stands still unless asked for, so it never ticks by accident
   always @(posedge clock) begin
      fs_count <= fs_count + 4'h1;
      low_freq_clock <= fs_on & fs_count[3];
   end
   // Hold one line at the opposite level for exactly w cycles
   task automatic pulse(input int ln, input int w);
      @(posedge clock);
      ext_irq_line[ln] <= ~ext_irq_line[ln];
      repeat (w) @(posedge clock);
      ext_irq_line[ln] <= ~ext_irq_line[ln];
   endtask
   // Move one line to a steady level
   task automatic drive(input int ln, input logic v);
      @(posedge clock);
      ext_irq_line[ln] <= v;
   endtask
endmodule
`default_nettype wire

// ---- dv/test_external_irq_filter_edge.sv ----
// Self-checking bench for the external interrupt conditioning block
`default_nettype none
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_external_irq_filter_edge
   import ext_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [9:0] address = 10'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [5:0] line;
   logic [5:0] request_latch;
   logic [5:0] irq_accept;
   logic [5:0] latch_clear = 6'h00;
   enable_t enables = '0;
   logic slow_mode = 1'b0;
   logic ce = 1'b1;
   logic fs_on = 1'b0;
   logic low_freq_clock;
   logic shared_pin_is_irq;
   logic [31:0] rdata; // Data of the last read
   int fails = 0;
   int num_checks = 0;
   // Filter table: line, control, pulse width, latch expected; last two in slow mode
   int f_ln[13] = '{5, 5, 2, 2, 1, 1, 1, 1, 0, 0, 0, 2, 2};
   int f_w[13] = '{1, 7, 6, 25, 62, 193, 14, 49, 1, 7, 20, 8, 56};
   logic [7:0] f_c[13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80,
      8'h40, 8'h40, 8'h00, 8'h00, 8'h00};
   logic f_e[13] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
      1'b0, 1'b1};
   // ------
   // Clock and instances
   // ------
   initial begin
      forever #2.5 clock = ~clock;
   end
   pin_source src (.clock(clock), .fs_on(fs_on), .ext_irq_line(line),
      .low_freq_clock(low_freq_clock));
   external_irq_filter_edge dut (.clock(clock), .srst(srst), .ce(ce), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .ext_irq_line(line),
      .low_freq_clock(low_freq_clock), .slow_mode(slow_mode), .enables(enables),
      .latch_clear(latch_clear), .request_latch(request_latch), .irq_accept(irq_accept),
      .shared_pin_is_irq(shared_pin_is_irq));
   // ------
   // Helpers
   // ------
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One access; everything held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [3:0] be,
         input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      read <= ~wr;
      write <= wr;
      byteenable <= be;
      writedata <= {24'h0, d};
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) fails++;
      rdata = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   // Control writes happen only with enables low, so glitches cannot be accepted
   task automatic ctl(input logic [7:0] d);
      bus(1'b1, CONTROL_ADDR, 4'h1, d);
   endtask
   task automatic clr();
      @(posedge clock);
      latch_clear <= 6'h3f;
      @(posedge clock);
      latch_clear <= 6'h00;
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ------
   // Scenarios
   // ------
   task automatic reg_check();
      bus(1'b0, CONTROL_ADDR, 4'h1, 8'h00);
      `CHECK(rdata, 32'h0)
      ctl(8'hff);
      bus(1'b1, CONTROL_ADDR, 4'h0, 8'h00); // Lane 0 not enabled: ignored
      bus(1'b1, 10'h3fc, 4'h1, 8'h00); // Unmapped: ignored
      bus(1'b0, CONTROL_ADDR, 4'h1, 8'h00);
      `CHECK(rdata, 32'hfe)
      `CHECK(shared_pin_is_irq, 1'b1)
      bus(1'b0, 10'h3fc, 4'h1, 8'h00);
      `CHECK(rdata, 32'h0)
      bus(1'b0, STATUS_ADDR, 4'h1, 8'h00);
      `CHECK(rdata, 32'h2100)
      ctl(8'h00);
      $display("Test registers done");
   endtask
   // Steady rise then fall on one line; latch checked after each and after a clear
   task automatic edge_check(input int ln, input logic [7:0] c, input logic er,
         input logic ef);
      ctl(c);
      src.drive(ln, 1'b1);
      cyc(30);
      `CHECK(request_latch[ln], er)
      clr();
      src.drive(ln, 1'b0);
      cyc(30);
      `CHECK(request_latch[ln], ef)
      clr();
      cyc(2);
      `CHECK(request_latch[ln], 1'b0)
   endtask
   // Waits 64 cycles after a control change so a new reject time has surely applied
   task automatic filt(input int i);
      ctl(f_c[i]);
      cyc(64);
      src.pulse(f_ln[i], f_w[i]);
      cyc(40);
      `CHECK(request_latch[f_ln[i]], f_e[i])
      clr();
   endtask
   task automatic accept_check();
      ctl(8'h40);
      src.pulse(0, 10);
      cyc(20);
      enables <= {1'b1, 6'h01};
      cyc(3);
      `CHECK(irq_accept, 6'h01)
      // Clock enable low must hold the latch against a clear
      ce <= 1'b0;
      latch_clear <= 6'h3f;
      cyc(3);
      `CHECK(request_latch[0], 1'b1)
      latch_clear <= 6'h00;
      ce <= 1'b1;
      enables <= {1'b0, 6'h01};
      cyc(3);
      `CHECK(irq_accept, 6'h00)
      enables <= {1'b1, 6'h00};
      cyc(3);
      `CHECK(irq_accept, 6'h00)
      enables <= '0;
      clr();
      ctl(8'h00);
      $display("Test accept done");
   endtask
   // Line 4 high through a reset must wait for a fresh rise
   task automatic reset_check();
      ctl(8'hb0);
      src.drive(4, 1'b1);
      cyc(30);
      `CHECK(request_latch[4], 1'b1)
      srst <= 1'b1;
      cyc(20);
      srst <= 1'b0;
      `CHECK(request_latch, 6'h00)
      bus(1'b0, CONTROL_ADDR, 4'h1, 8'h00);
      `CHECK(rdata, 32'h0)
      ctl(8'hb0);
      cyc(30);
      `CHECK(request_latch[4], 1'b0)
      src.drive(4, 1'b0);
      cyc(30);
      src.drive(4, 1'b1);
      cyc(30);
      `CHECK(request_latch[4], 1'b1)
      src.drive(4, 1'b0);
      cyc(30);
      ctl(8'h00);
      clr();
      $display("Test reset done");
   endtask
   // ------
   // Main sequence and watchdog
   // ------
   initial begin
      cyc(20);
      srst <= 1'b0;
      cyc(8);
      reg_check();
      for (int ln = 1; ln <= 3; ln++) begin
         for (int f = 0; f < 2; f++) begin
            edge_check(ln, 8'h80 | 8'(f << ln), f == 0, f == 1);
         end
      end
      for (int m = 0; m < 4; m++) begin
         edge_check(4, 8'h80 | 8'(m << 4), m != 1, m != 0);
      end
      $display("Test edges done");
      for (int i = 0; i < 13; i++) begin
         if (i == 11) begin
            slow_mode <= 1'b1;
            fs_on <= 1'b1;
         end
         filt(i);
      end
      slow_mode <= 1'b0;
      fs_on <= 1'b0;
      $display("Test filters done");
      accept_check();
      reset_check();
      conclude();
   end
   // Whole run needs about 3000 cycles
   initial begin
      cyc(20000);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
